// ==== inc/msi_pkg.sv ====
// Constants and types for the management serial port and interrupt logic.
// Assumes a 100 MHz core clock and status inputs from the same clock.
package msi_pkg;

  // ***********************************************
  // Timing
  // ***********************************************
  localparam int CLK_HZ          = 100_000_000;
  localparam int CLK_PER_MS      = CLK_HZ / 1000;
  localparam int ENERGY_LATE_MS  = 1000;
  localparam int ENERGY_HOLD_MS  = 256;
  localparam int ENERGY_LATE_CYC = ENERGY_LATE_MS * CLK_PER_MS;
  localparam int ENERGY_HOLD_CYC = ENERGY_HOLD_MS * CLK_PER_MS;

  // ***********************************************
  // Frame layout
  // ***********************************************
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [3:0] HDR_LAST     = 4'hc;
  localparam logic [3:0] TA_LAST      = 4'h1;
  localparam logic [3:0] DATA_LAST    = 4'hf;
  localparam logic [1:0] OP_READ      = 2'h2;
  localparam logic [1:0] OP_WRITE     = 2'h1;
  localparam logic [1:0] STRAP_LATCH  = 2'h2;
  localparam logic [1:0] STRAP_DONE   = 2'h3;

  // ***********************************************
  // Register indices and bit positions
  // ***********************************************
  localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
  localparam logic [4:0] REG_LP_ABILITY   = 5'h05;
  localparam logic [4:0] REG_AN_EXPANSION = 5'h06;
  localparam logic [4:0] REG_STD_LAST     = 5'h06;
  localparam logic [4:0] REG_VENDOR_FIRST = 5'h10;
  localparam logic [4:0] REG_MODE_CTRL    = 5'h11;
  localparam logic [4:0] REG_IRQ_FLAGS    = 5'h1d;
  localparam logic [4:0] REG_IRQ_MASK     = 5'h1e;

  localparam int BIT_AN_DONE  = 5;
  localparam int BIT_RFAULT   = 4;
  localparam int BIT_LINK     = 2;
  localparam int BIT_LP_ACK   = 14;
  localparam int BIT_PD_FAULT = 4;
  localparam int BIT_PAGE_RX  = 1;
  localparam int BIT_ENERGY   = 1;
  localparam int BIT_ALT_MODE = 6;
  localparam int IRQ_ENERGY   = 7;
  localparam int IRQ_LINK     = 4;

  localparam logic [15:0] UNMAPPED_READ = 16'hffff;
  localparam logic [7:0]  FLAG_RESET    = 8'h80;
  localparam logic [7:0]  PREV_RESET    = 8'h80;
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [7:0]  FALL_CLR      = 8'hee;
  localparam logic [7:0]  RD1_CLR       = 8'h30;
  localparam logic [7:0]  RD6_CLR       = 8'h06;

  // ***********************************************
  // Types
  // ***********************************************
  typedef struct packed {
    logic energyDetect;
    logic anComplete;
    logic remoteFault;
    logic linkStatus;
    logic lpAck;
    logic pdFault;
    logic pageRx;
  } msi_status_t;

  typedef struct packed {
    logic        strobe;
    logic [4:0]  addr;
    logic [15:0] data;
  } msi_reg_wr_t;

  typedef enum {MSI_PRE, MSI_HDR, MSI_TA, MSI_DATA} msi_frame_state_t;

endpackage

// ==== src/msi_mgmt_irq.sv ====
// Serial management slave with register file and interrupt generation.
// Assumes mdc and mdio come from pins; status and anRestart from core logic.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Registers 0-6 and 16-31 reachable serially
// - Unimplemented registers read as ffff
// - Aperiodic management clock, no maximum gap
// - Receiver samples data on rising clock
// - Answer only own strapped address
// - Active-low interrupt from masked events
// - Both modes assert identically
// - Mode bit zero primary, forced at reset
// - Seven events fire on source rising edge
// - Primary: source fall (not link-down) or flag read releases
// - Remote fault, link-down also by status read
// - Detect fault, page: expansion read, restart, link loss
// - Energy echo one second after fall
// - Energy flag reads one at power-up if energy present
// - Alternate: clearing mask releases immediately
// - Alternate: writing one rechecks the source
// - Alternate: clear only when source inactive
// - Flags mark cause, same position as mask
module msi_mgmt_irq
  import msi_pkg::*;
#(
  parameter int ENERGY_LATE = msi_pkg::ENERGY_LATE_CYC,
  parameter int ENERGY_HOLD = msi_pkg::ENERGY_HOLD_CYC
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                mdc,
  input  wire logic                mdioIn,
  output logic                     mdioOut,
  output logic                     mdioOe,
  input  wire logic [2:0]          device_addr_strap,
  input  wire msi_pkg::msi_status_t status,
  input  wire logic                anRestart,
  output logic                     irq_out_n,
  output msi_pkg::msi_reg_wr_t     regWr
);
  import msi_pkg::*;

  // ***********************************************
  // Pin synchronisers and address strap
  // ***********************************************
  logic [1:0] mdcSync;
  logic [1:0] next_mdcSync;
  logic [1:0] mdioSync;
  logic [1:0] next_mdioSync;
  logic [2:0] strapMeta;
  logic [2:0] strapSync;
  logic [1:0] strapStage;
  logic [1:0] next_strapStage;
  logic [4:0] devAddr;
  logic [4:0] next_devAddr;
  logic       mdcLast;
  logic       mdcRise;
  logic       mdioS;

  always_comb begin
    next_mdcSync    = {mdcSync[0], mdc};
    next_mdioSync   = {mdioSync[0], mdioIn};
    next_strapStage = strapStage;
    next_devAddr    = devAddr;
    if (strapStage != STRAP_DONE) begin
      next_strapStage = strapStage + 2'h1;
    end
    if (strapStage == STRAP_LATCH) begin
      next_devAddr = {2'h0, strapSync};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mdcSync    <= 2'h0;
      mdioSync   <= 2'h0;
      strapMeta  <= 3'h0;
      strapSync  <= 3'h0;
      strapStage <= 2'h0;
      devAddr    <= 5'h00;
      mdcLast    <= 1'b0;
    end else begin
      mdcSync    <= next_mdcSync;
      mdioSync   <= next_mdioSync;
      strapMeta  <= device_addr_strap;
      strapSync  <= strapMeta;
      strapStage <= next_strapStage;
      devAddr    <= next_devAddr;
      mdcLast    <= mdcSync[1];
    end
  end

  // No timing assumed between edges, only the edge itself
  assign mdcRise = mdcSync[1] & ~mdcLast;
  assign mdioS   = mdioSync[1];

  // ***********************************************
  // Frame engine
  // ***********************************************
  msi_frame_state_t state;
  msi_frame_state_t next_state;
  logic [5:0]  preCnt;
  logic [5:0]  next_preCnt;
  logic [3:0]  bitCnt;
  logic [3:0]  next_bitCnt;
  logic [11:0] hdr;
  logic [11:0] next_hdr;
  logic [15:0] sh;
  logic [15:0] next_sh;
  logic        isRead;
  logic        next_isRead;
  logic        isMine;
  logic        next_isMine;
  logic [4:0]  regAddr;
  logic [4:0]  next_regAddr;
  logic        next_mdioOut;
  logic        next_mdioOe;
  logic [12:0] hdrNow;
  logic [15:0] readValue;
  logic        rdTake;
  logic        wrTake;
  logic [15:0] wrData;

  assign hdrNow = {hdr, mdioS};
  assign wrData = {sh[14:0], mdioS};

  always_comb begin
    next_state   = state;
    next_preCnt  = preCnt;
    next_bitCnt  = bitCnt;
    next_hdr     = hdr;
    next_sh      = sh;
    next_isRead  = isRead;
    next_isMine  = isMine;
    next_regAddr = regAddr;
    next_mdioOut = mdioOut;
    next_mdioOe  = mdioOe;
    rdTake       = 1'b0;
    wrTake       = 1'b0;
    if (mdcRise) begin
      case (state)
        MSI_PRE: begin
          if (mdioS) begin
            if (preCnt != PREAMBLE_LEN) begin
              next_preCnt = preCnt + 6'h01;
            end
          end else begin
            next_preCnt = 6'h00;
            if (preCnt == PREAMBLE_LEN) begin
              next_state  = MSI_HDR;
              next_bitCnt = 4'h0;
            end
          end
        end
        MSI_HDR: begin
          next_hdr    = hdrNow[11:0];
          next_bitCnt = bitCnt + 4'h1;
          if (bitCnt == HDR_LAST) begin
            next_bitCnt  = 4'h0;
            next_isRead  = hdrNow[11:10] == OP_READ;
            next_isMine  = hdrNow[9:5] == devAddr;
            next_regAddr = hdrNow[4:0];
            next_state   = MSI_TA;
            if (!hdrNow[12] || (hdrNow[11:10] != OP_READ
                && hdrNow[11:10] != OP_WRITE)) begin
              next_state = MSI_PRE;
            end else if (hdrNow[11:10] == OP_READ
                         && hdrNow[9:5] == devAddr) begin
              rdTake  = 1'b1;
              next_sh = readValue;
            end
          end
        end
        MSI_TA: begin
          next_bitCnt = bitCnt + 4'h1;
          if (isRead && isMine) begin
            next_mdioOe  = 1'b1;
            next_mdioOut = 1'b0;
            if (bitCnt == TA_LAST) begin
              next_mdioOut = sh[15];
              next_sh      = {sh[14:0], 1'b0};
            end
          end
          if (bitCnt == TA_LAST) begin
            next_bitCnt = 4'h0;
            next_state  = MSI_DATA;
          end
        end
        MSI_DATA: begin
          next_bitCnt = bitCnt + 4'h1;
          if (isRead && isMine) begin
            next_mdioOut = sh[15];
            next_sh      = {sh[14:0], 1'b0};
          end else begin
            next_sh = wrData;
          end
          if (bitCnt == DATA_LAST) begin
            next_bitCnt  = 4'h0;
            next_state   = MSI_PRE;
            next_mdioOe  = 1'b0;
            next_mdioOut = 1'b0;
            wrTake       = !isRead && isMine;
          end
        end
        default: begin
          next_state = MSI_PRE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= MSI_PRE;
      preCnt  <= 6'h00;
      bitCnt  <= 4'h0;
      hdr     <= 12'h000;
      sh      <= 16'h0000;
      isRead  <= 1'b0;
      isMine  <= 1'b0;
      regAddr <= 5'h00;
      mdioOut <= 1'b0;
      mdioOe  <= 1'b0;
    end else begin
      state   <= next_state;
      preCnt  <= next_preCnt;
      bitCnt  <= next_bitCnt;
      hdr     <= next_hdr;
      sh      <= next_sh;
      isRead  <= next_isRead;
      isMine  <= next_isMine;
      regAddr <= next_regAddr;
      mdioOut <= next_mdioOut;
      mdioOe  <= next_mdioOe;
    end
  end

  // ***********************************************
  // Registers and interrupt flags
  // ***********************************************
  logic [15:0] regFile [0:31];
  logic [15:0] next_regFile [0:31];
  logic [7:0]  flags;
  logic [7:0]  next_flags;
  logic [7:0]  mask;
  logic [7:0]  next_mask;
  logic [7:0]  srcPrev;
  logic        altMode;
  logic        next_altMode;
  logic        next_irqOutN;
  msi_reg_wr_t next_regWr;
  logic [7:0]  src;
  logic [7:0]  rise;
  logic [7:0]  fall;
  logic [7:0]  flagSet;
  logic [7:0]  flagClr;
  logic        rd1;
  logic        rd6;
  logic        rd29;
  logic        wr29;
  logic        echoSet;
  logic        echoClr;

  // Link-down is carried inverted so every event is a rising edge
  assign src  = {status.energyDetect, status.anComplete, status.remoteFault,
                 ~status.linkStatus, status.lpAck, status.pdFault,
                 status.pageRx, 1'b0};
  assign rise = src & ~srcPrev;
  assign fall = ~src & srcPrev;
  assign rd1  = rdTake && hdrNow[4:0] == REG_BASIC_STATUS;
  assign rd6  = rdTake && hdrNow[4:0] == REG_AN_EXPANSION;
  assign rd29 = rdTake && hdrNow[4:0] == REG_IRQ_FLAGS;
  assign wr29 = wrTake && regAddr == REG_IRQ_FLAGS;
  assign flagSet[0] = 1'b0;
  assign flagClr[0] = 1'b1;

  genvar gi;
  generate
    for (gi = 1; gi < 8; gi++) begin : g_flag
      logic primClr;
      logic altClr;
      assign primClr = (fall[gi] & FALL_CLR[gi]) | rd29
                     | (rd1 & RD1_CLR[gi])
                     | ((rd6 | anRestart | rise[IRQ_LINK])
                        & RD6_CLR[gi]);
      assign altClr  = wr29 & wrData[gi] & ~src[gi];
      assign flagClr[gi] = (altMode ? altClr : primClr)
                         | (echoClr & (gi == IRQ_ENERGY));
      assign flagSet[gi] = rise[gi] | (echoSet & (gi == IRQ_ENERGY));
    end
  endgenerate

  always_comb begin
    readValue = UNMAPPED_READ;
    if (hdrNow[4:0] <= REG_STD_LAST || hdrNow[4:0] >= REG_VENDOR_FIRST) begin
      readValue = regFile[hdrNow[4:0]];
      case (hdrNow[4:0])
        REG_BASIC_STATUS: begin
          readValue[BIT_AN_DONE] = status.anComplete;
          readValue[BIT_RFAULT]  = status.remoteFault;
          readValue[BIT_LINK]    = status.linkStatus;
        end
        REG_LP_ABILITY: begin
          readValue[BIT_LP_ACK] = status.lpAck;
        end
        REG_AN_EXPANSION: begin
          readValue[BIT_PD_FAULT] = status.pdFault;
          readValue[BIT_PAGE_RX]  = status.pageRx;
        end
        REG_MODE_CTRL: begin
          readValue[BIT_ENERGY]   = status.energyDetect;
          readValue[BIT_ALT_MODE] = altMode;
        end
        REG_IRQ_FLAGS: begin
          readValue = {8'h00, flags};
        end
        REG_IRQ_MASK: begin
          readValue = {8'h00, mask};
        end
        default: begin
          readValue = regFile[hdrNow[4:0]];
        end
      endcase
    end
  end

  always_comb begin
    next_regFile = regFile;
    next_mask    = mask;
    next_altMode = altMode;
    // Set wins over a clear in the same cycle
    next_flags   = (flags & ~flagClr) | flagSet;
    if (wrTake && regAddr != REG_IRQ_FLAGS) begin
      next_regFile[regAddr] = wrData;
    end
    if (wrTake && regAddr == REG_IRQ_MASK) begin
      next_mask = {wrData[7:1], 1'b0};
    end
    if (wrTake && regAddr == REG_MODE_CTRL) begin
      next_altMode = wrData[BIT_ALT_MODE];
    end
    // Mask gates the output, so clearing it releases at once
    next_irqOutN = ~|(next_flags & next_mask);
    next_regWr   = '{strobe: wrTake, addr: regAddr, data: wrData};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        regFile[i] <= 16'h0000;
      end
      flags     <= FLAG_RESET;
      mask      <= MASK_RESET;
      srcPrev   <= PREV_RESET;
      altMode   <= 1'b0;
      irq_out_n <= 1'b1;
      regWr     <= '0;
    end else begin
      regFile   <= next_regFile;
      flags     <= next_flags;
      mask      <= next_mask;
      srcPrev   <= src;
      altMode   <= next_altMode;
      irq_out_n <= next_irqOutN;
      regWr     <= next_regWr;
    end
  end

  // ***********************************************
  // Energy-detect late echo
  // ***********************************************
  logic        echoArm;
  logic        next_echoArm;
  logic        echoWait;
  logic        next_echoWait;
  logic        echoHold;
  logic        next_echoHold;
  logic [31:0] echoCnt;
  logic [31:0] next_echoCnt;

  always_comb begin
    next_echoArm  = echoArm;
    next_echoWait = echoWait;
    next_echoHold = echoHold;
    next_echoCnt  = echoCnt;
    echoSet       = 1'b0;
    echoClr       = 1'b0;
    // Released by a flag read while energy still present
    if (rd29 && !altMode && flags[IRQ_ENERGY] && src[IRQ_ENERGY]
        && mask[IRQ_ENERGY]) begin
      next_echoArm = 1'b1;
    end
    if (echoArm && fall[IRQ_ENERGY]) begin
      next_echoArm  = 1'b0;
      next_echoWait = 1'b1;
      next_echoCnt  = 32'h0000_0000;
    end
    if (echoWait) begin
      next_echoCnt = echoCnt + 32'h0000_0001;
      if (echoCnt == 32'(ENERGY_LATE - 1)) begin
        next_echoWait = 1'b0;
        next_echoHold = 1'b1;
        next_echoCnt  = 32'h0000_0000;
        echoSet       = 1'b1;
      end
    end
    if (echoHold) begin
      next_echoCnt = echoCnt + 32'h0000_0001;
      if (echoCnt == 32'(ENERGY_HOLD - 1)) begin
        next_echoHold = 1'b0;
        echoClr       = 1'b1;
      end
    end
    // Clearing the energy mask cancels any pending echo
    if (!mask[IRQ_ENERGY]) begin
      next_echoArm  = 1'b0;
      next_echoWait = 1'b0;
      next_echoHold = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      echoArm  <= 1'b0;
      echoWait <= 1'b0;
      echoHold <= 1'b0;
      echoCnt  <= 32'h0000_0000;
    end else begin
      echoArm  <= next_echoArm;
      echoWait <= next_echoWait;
      echoHold <= next_echoHold;
      echoCnt  <= next_echoCnt;
    end
  end

endmodule

`default_nettype wire

// ==== testbench/msi_mgmt_irq_asserts.sv ====
// Port-level checks for the management serial and interrupt block.
// Assumes one core_clk domain; mask is shadowed from the write strobe.
`timescale 1ns/100ps
`default_nettype none
module msi_mgmt_irq_asserts
  import msi_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire logic                 mdioOut,
  input wire logic                 mdioOe,
  input wire msi_pkg::msi_status_t status,
  input wire logic                 irq_out_n,
  input wire msi_pkg::msi_reg_wr_t regWr
);
  import msi_pkg::*;
  logic [7:1] maskSh;
  logic [7:1] next_maskSh;

  // ***********************************************
  // Mask shadow
  // ***********************************************
  always_comb begin
    next_maskSh = maskSh;
    if (regWr.strobe && regWr.addr == REG_IRQ_MASK) begin
      next_maskSh = regWr.data[7:1];
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      maskSh <= '0;
    end else begin
      maskSh <= next_maskSh;
    end
  end

  // ***********************************************
  // Properties
  // ***********************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  idle_low_a: assert property (!mdioOe |-> !mdioOut)
    else $error("data driven while released");
  oe_hold_a: assert property ($rose(mdioOe) |-> mdioOe[*8])
    else $error("read drive too short");
  first_zero_a: assert property ($rose(mdioOe) |-> !mdioOut)
    else $error("turnaround bit not zero");
  wr_pulse_a: assert property (regWr.strobe |=> !regWr.strobe)
    else $error("write strobe longer than one cycle");
  wr_quiet_a: assert property (regWr.strobe |-> !mdioOe)
    else $error("line driven during write");
  mask_quiet_a: assert property (maskSh == 7'h00 && !regWr.strobe
    |=> irq_out_n || regWr.strobe)
    else $error("interrupt with all events masked");
  event_fire_a: assert property (
    $rose(status.anComplete) && maskSh[6] |-> ##[1:2] !irq_out_n)
    else $error("rising source did not interrupt");
  link_fall_a: assert property (
    $fell(status.linkStatus) && maskSh[4] |-> ##[1:2] !irq_out_n)
    else $error("link loss did not interrupt");
endmodule
bind msi_mgmt_irq msi_mgmt_irq_asserts chk_u (
  .core_clk (core_clk),
  .rst_n    (rst_n),
  .mdioOut  (mdioOut),
  .mdioOe   (mdioOe),
  .status   (status),
  .irq_out_n(irq_out_n),
  .regWr    (regWr)
);
`default_nettype wire

// ==== testbench/msi_station_mgr.sv ====
// Station manager model: drives the management clock and data wire.
// Assumes changes on core_clk falling edges; wire has a pull-up.
`timescale 1ns/100ps
`default_nettype none
module msi_station_mgr (
  input  wire logic core_clk,
  input  wire logic mdioOut,
  input  wire logic mdioOe,
  output var  logic mdc,
  output logic      mdioIn
);
  logic mgrOe;
  logic mgrBit;
  int   lowCyc;

  initial begin
    mdc    = 1'b0;
    mgrOe  = 1'b0;
    mgrBit = 1'b1;
    lowCyc = 4;
  end

  // Wire level, pulled high when released
  assign mdioIn = mdioOe ? mdioOut : (mgrOe ? mgrBit : 1'b1);

  // One bit: low half of lowCyc, high half of 4 core cycles
  task automatic bitCycle(input logic drive, input logic b,
                          output logic seen);
    mgrOe  = drive;
    mgrBit = b;
    repeat (lowCyc) @(negedge core_clk);
    mdc  = 1'b1;
    seen = mdioIn;
    repeat (4) @(negedge core_clk);
    mdc = 1'b0;
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] regIdx, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [45:0] hdr;
    logic        s;
    hdr = {32'hffffffff, 2'b01, op, phy, regIdx};
    for (int i = 45; i >= 0; i--) begin
      bitCycle(1'b1, hdr[i], s);
    end
    if (op == 2'h2) begin
      bitCycle(1'b0, 1'b1, s);
      bitCycle(1'b0, 1'b1, s);
      for (int i = 15; i >= 0; i--) begin
        bitCycle(1'b0, 1'b1, rd[i]);
      end
    end else begin
      bitCycle(1'b1, 1'b1, s);
      bitCycle(1'b1, 1'b0, s);
      for (int i = 15; i >= 0; i--) begin
        bitCycle(1'b1, wd[i], s);
      end
      rd = wd;
    end
    mgrOe = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/msi_mgmt_irq_test.sv ====
// Self-checking bench: register access and interrupt modes.
// Assumes station manager model drives mdc and the data wire.
`timescale 1ns/100ps
`default_nettype none
module msi_mgmt_irq_test;
  import msi_pkg::*;
  localparam int LATE = 40;
  localparam int HOLD = 20;
  localparam logic [4:0] ADDR = 5'h05;
  logic        core_clk;
  logic        rst_n;
  logic        mdc;
  logic        mdioIn;
  logic        mdioOut;
  logic        mdioOe;
  logic        anRestart;
  logic        irq_out_n;
  logic [2:0]  strap;
  logic [15:0] junk;
  msi_status_t status;
  msi_reg_wr_t regWr;
  int          errCount;
  int          cmpCount;
  msi_reg_wr_t lastWr;

  msi_station_mgr mgr_u (.core_clk(core_clk), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .mdc(mdc), .mdioIn(mdioIn));
  msi_mgmt_irq #(.ENERGY_LATE(LATE), .ENERGY_HOLD(HOLD)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .mdc(mdc), .mdioIn(mdioIn),
    .mdioOut(mdioOut), .mdioOe(mdioOe), .device_addr_strap(strap),
    .status(status), .anRestart(anRestart), .irq_out_n(irq_out_n),
    .regWr(regWr));

  // Last write the block reported
  always @(posedge core_clk) begin
    if (regWr.strobe) begin
      lastWr <= regWr;
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ***********************************************
  // Tasks
  // ***********************************************
  task automatic closeOut();
    if (errCount == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk16(input string n, input logic [15:0] e, got);
    cmpCount++;
    if (got !== e) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", n, e, got);
    end
  endtask
  task automatic chk1(input string n, input logic e, got);
    cmpCount++;
    if (got !== e) begin
      errCount++;
      $display("mismatch %s expected %b seen %b", n, e, got);
    end
  endtask
  task automatic rd(input logic [4:0] phy, idx, input logic [15:0] e);
    logic [15:0] got;
    mgr_u.frame(OP_READ, phy, idx, 16'h0000, got);
    chk16("read data", e, got);
  endtask
  task automatic wr(input logic [4:0] phy, idx, input logic [15:0] d);
    mgr_u.frame(OP_WRITE, phy, idx, d, junk);
    repeat (8) @(negedge core_clk);
  endtask
  task automatic pin(input logic e);
    repeat (3) @(negedge core_clk);
    chk1("irq_out_n", e, irq_out_n);
  endtask

  // ***********************************************
  // Sequence
  // ***********************************************
  initial begin
    rst_n = 1'b0;
    anRestart = 1'b0;
    strap = 3'h5;
    status = 7'h48;
    errCount = 0;
    cmpCount = 0;
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge core_clk);
    chk1("irq_out_n", 1'b1, irq_out_n);
    rd(ADDR, REG_IRQ_FLAGS, 16'h0080);
    rd(ADDR, REG_IRQ_FLAGS, 16'h0000);
    rd(ADDR, REG_IRQ_MASK, 16'h0000);
    rd(ADDR, REG_MODE_CTRL, 16'h0002);
    rd(ADDR, 5'h07, UNMAPPED_READ);
    rd(ADDR, 5'h0f, UNMAPPED_READ);
    wr(ADDR, REG_VENDOR_FIRST, 16'ha5c3);
    rd(ADDR, REG_VENDOR_FIRST, 16'ha5c3);
    wr(ADDR, 5'h1f, 16'h5a3c);
    chk16("write data", 16'h5a3c, lastWr.data);
    chk16("write address", 16'h001f, {11'h000, lastWr.addr});
    rd(ADDR, 5'h1f, 16'h5a3c);
    wr(5'h04, REG_VENDOR_FIRST, 16'h0000);
    chk16("write data", 16'h5a3c, lastWr.data);
    rd(5'h04, REG_VENDOR_FIRST, 16'hffff);
    // Reserved opcode is ignored
    mgr_u.frame(2'h3, ADDR, REG_VENDOR_FIRST, 16'h0000, junk);
    chk16("write data", 16'h5a3c, lastWr.data);
    mgr_u.lowCyc = 29;
    rd(ADDR, REG_VENDOR_FIRST, 16'ha5c3);
    mgr_u.lowCyc = 4;
    // Primary mode, one release path per source
    wr(ADDR, REG_IRQ_MASK, 16'h00fe);
    rd(ADDR, REG_IRQ_MASK, 16'h00fe);
    status[5] = 1'b1;
    pin(1'b0);
    status[5] = 1'b0;
    pin(1'b1);
    status[4] = 1'b1;
    pin(1'b0);
    mgr_u.frame(OP_READ, ADDR, REG_BASIC_STATUS, 16'h0000, junk);
    pin(1'b1);
    status[4] = 1'b0;
    status[3] = 1'b0;
    pin(1'b0);
    rd(ADDR, REG_IRQ_FLAGS, 16'h0010);
    pin(1'b1);
    status[3] = 1'b1;
    status[2] = 1'b1;
    pin(1'b0);
    status[2] = 1'b0;
    pin(1'b1);
    status[1] = 1'b1;
    pin(1'b0);
    mgr_u.frame(OP_READ, ADDR, REG_AN_EXPANSION, 16'h0000, junk);
    pin(1'b1);
    status[1] = 1'b0;
    status[0] = 1'b1;
    pin(1'b0);
    anRestart = 1'b1;
    @(negedge core_clk);
    anRestart = 1'b0;
    pin(1'b1);
    status[0] = 1'b0;
    pin(1'b1);
    status[0] = 1'b1;
    pin(1'b0);
    // Link loss three cycles apart, so no set meets the clear
    status[3] = 1'b0;
    pin(1'b0);
    rd(ADDR, REG_IRQ_FLAGS, 16'h0010);
    status[3] = 1'b1;
    status[0] = 1'b0;
    // Energy echo after release while still high
    status[6] = 1'b0;
    pin(1'b1);
    status[6] = 1'b1;
    pin(1'b0);
    rd(ADDR, REG_IRQ_FLAGS, 16'h0080);
    pin(1'b1);
    status[6] = 1'b0;
    repeat (20) @(negedge core_clk);
    chk1("irq_out_n", 1'b1, irq_out_n);
    repeat (30) @(negedge core_clk);
    chk1("irq_out_n", 1'b0, irq_out_n);
    repeat (30) @(negedge core_clk);
    chk1("irq_out_n", 1'b1, irq_out_n);
    // Alternate mode
    wr(ADDR, REG_MODE_CTRL, 16'h0040);
    rd(ADDR, REG_MODE_CTRL, 16'h0040);
    status[5] = 1'b1;
    pin(1'b0);
    wr(ADDR, REG_IRQ_FLAGS, 16'h0040);
    pin(1'b0);
    status[5] = 1'b0;
    pin(1'b0);
    wr(ADDR, REG_IRQ_FLAGS, 16'h0040);
    pin(1'b1);
    status[3] = 1'b0;
    pin(1'b0);
    wr(ADDR, REG_IRQ_FLAGS, 16'h0010);
    pin(1'b0);
    status[3] = 1'b1;
    wr(ADDR, REG_IRQ_FLAGS, 16'h0010);
    pin(1'b1);
    status[2] = 1'b1;
    pin(1'b0);
    wr(ADDR, REG_IRQ_MASK, 16'h00f6);
    pin(1'b1);
    status[2] = 1'b0;
    closeOut();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    errCount++;
    closeOut();
  end
endmodule
`default_nettype wire
